// ---- src/sgan_pkg.sv ----
package sgan_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int LINK_TIMER_X_NS = 10_000_000;
  localparam int LINK_TIMER_SGMII_NS = 1_600_000;
  localparam int LINK_TIMER_SHORT_NS = 2_000;
  localparam int LINK_TIMER_X_CYC = LINK_TIMER_X_NS / CLK_PERIOD_NS;
  localparam int LINK_TIMER_SGMII_CYC = LINK_TIMER_SGMII_NS / CLK_PERIOD_NS;
  localparam int LINK_TIMER_SHORT_CYC = LINK_TIMER_SHORT_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 21;
  localparam logic [1:0] MATCH_CNT = 2'h3;
  // ==========================================================
  // register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADV = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PARTNER = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam int CTRL_SHORT_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  localparam logic [15:0] ADV_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int IRQ_UP_BIT = 0;
  localparam int IRQ_DOWN_BIT = 1;
  localparam int IRQ_PAGE_BIT = 2;
  localparam int IRQ_W = 3;
  // ==========================================================
  // ability word
  localparam int ACK_BIT = 14;
  localparam logic [15:0] ACK_MASK = 16'hBFFF;
  localparam logic [15:0] MAC_WORD = 16'h4001;
  // ==========================================================
  // types
  typedef enum logic [6:0] {
    S_DISABLED = 7'h01,
    S_START = 7'h02,
    S_ABILITY = 7'h04,
    S_ACK = 7'h08,
    S_IDLE = 7'h10,
    S_LINK_OK = 7'h20,
    S_SPARE = 7'h40
  } sgan_state_t;
  typedef struct packed {
    logic sync_ok;
    logic cfg_valid;
    logic idle;
    logic [15:0] word;
  } sgan_rx_t;
  typedef struct packed {
    logic cfg_en;
    logic idle_en;
    logic [15:0] word;
  } sgan_tx_t;
endpackage

// ---- src/sgan_autoneg.sv ----
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module sgan_autoneg import sgan_pkg::*; #(
  parameter int LINK_TIMER_X_CYCLES = LINK_TIMER_X_CYC,
  parameter int LINK_TIMER_SGMII_CYCLES = LINK_TIMER_SGMII_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mode_sgmii_pin,
  input wire logic side_phy_pin,
  input wire sgan_rx_t link_rx,
  output sgan_tx_t link_tx,
  output logic negotiation_done,
  output logic partner_page_received,
  output logic [15:0] partner_ability_word,
  output logic data_allowed,
  output logic irq,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  localparam int TMAX = (1 << TIMER_W) - 1;
  if (LINK_TIMER_X_CYCLES < 1 || LINK_TIMER_X_CYCLES > TMAX ||
      LINK_TIMER_SGMII_CYCLES < 1 || LINK_TIMER_SGMII_CYCLES > TMAX) begin : g_chk
    $error("link timer count does not fit the timer");
  end

  // ==========================================================
  // pin synchronisers
  logic [1:0] mode_sync_ff, side_sync_ff;
  logic mode_sgmii_ff, side_phy_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_sync_ff <= 2'h0;
      side_sync_ff <= 2'h0;
    end else begin
      mode_sync_ff <= {mode_sync_ff[0], mode_sgmii_pin};
      side_sync_ff <= {side_sync_ff[0], side_phy_pin};
    end
  end
  assign mode_sgmii_ff = mode_sync_ff[1];
  assign side_phy_ff = side_sync_ff[1];

  // ==========================================================
  // register bus
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff, wdata_ff;
  logic [7:0] awaddr_ff;
  logic [3:0] wstrb_ff;
  logic [2:0] ctrl_ff;
  logic restart_req_ff;
  logic [15:0] adv_ff;
  logic [IRQ_W-1:0] irq_sts_ff, irq_mask_ff, irq_set;
  sgan_state_t state_ff, nxt_state;
  logic page_rx_ff, done_ff, allowed_ff, irq_ff;
  logic [15:0] partner_ff;
  logic wr_go, rd_go;
  logic [7:0] wa, ra;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign wa = {awaddr_ff[7:2], 2'h0};
  assign ra = {araddr[7:2], 2'h0};
  assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;
  assign rd_go = arvalid && arready_ff;

  // address and data taken in either order; response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end else begin
      if (awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        awaddr_ff <= awaddr;
      end
      if (wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (wa == OFS_CTRL || wa == OFS_ADV || wa == OFS_IRQ_MASK) ?
                    RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  logic [31:0] wmerged, wadv;
  assign wmerged = merge(32'h0, wdata_ff, wstrb_ff);
  assign wadv = merge({16'h0, adv_ff}, wdata_ff, wstrb_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RESET;
      restart_req_ff <= 1'b0;
      adv_ff <= ADV_RESET;
      irq_mask_ff <= '0;
    end else begin
      restart_req_ff <= 1'b0;
      if (wr_go && wa == OFS_CTRL && wstrb_ff[0]) begin
        ctrl_ff <= wdata_ff[2:0] & 3'h5;
        restart_req_ff <= wdata_ff[CTRL_RESTART_BIT];
      end
      if (wr_go && wa == OFS_ADV) begin
        adv_ff <= wadv[15:0];
      end
      if (wr_go && wa == OFS_IRQ_MASK && wstrb_ff[0]) begin
        irq_mask_ff <= wmerged[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
    end else begin
      if (rd_go) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rresp_ff <= RESP_OKAY;
        case (ra)
          OFS_CTRL: rdata_ff <= {29'h0, ctrl_ff};
          OFS_ADV: rdata_ff <= {16'h0, adv_ff};
          OFS_STATUS: rdata_ff <= {17'h0, state_ff, 3'h0, side_phy_ff, mode_sgmii_ff,
                                   link_rx.sync_ok, page_rx_ff, done_ff};
          OFS_PARTNER: rdata_ff <= {16'h0, partner_ff};
          OFS_IRQ_STS: rdata_ff <= {29'h0, irq_sts_ff};
          OFS_IRQ_MASK: rdata_ff <= {29'h0, irq_mask_ff};
          default: begin
            rdata_ff <= 32'h0;
            rresp_ff <= RESP_SLVERR;
          end
        endcase
      end
      if (rvalid_ff && rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // local ability word
  logic enable, short_tmr;
  logic [15:0] loc_word, loc_prev_ff;
  logic mode_prev_ff, side_prev_ff;
  assign enable = ctrl_ff[CTRL_EN_BIT];
  assign short_tmr = ctrl_ff[CTRL_SHORT_BIT];

  always_comb begin
    if (!mode_sgmii_ff) begin
      loc_word = {adv_ff[15], 1'b0, adv_ff[13:12], 3'h0, adv_ff[8:5], 5'h00};
    end else if (side_phy_ff) begin
      loc_word = {adv_ff[15], 2'h0, adv_ff[12], adv_ff[11:10], 9'h000, 1'b1};
    end else begin
      loc_word = MAC_WORD;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loc_prev_ff <= 16'h0;
      mode_prev_ff <= 1'b0;
      side_prev_ff <= 1'b0;
    end else begin
      loc_prev_ff <= loc_word;
      mode_prev_ff <= mode_sgmii_ff;
      side_prev_ff <= side_phy_ff;
    end
  end

  logic mode_chg, adv_chg_phy, restart_evt;
  assign mode_chg = (mode_prev_ff != mode_sgmii_ff) || (side_prev_ff != side_phy_ff);
  assign adv_chg_phy = mode_sgmii_ff && side_phy_ff && (loc_word != loc_prev_ff);

  // ==========================================================
  // partner word matching
  logic [15:0] rx_last_ff;
  logic [1:0] match_cnt_ff, idle_cnt_ff;
  logic ability_match, ack_match, idle_match;
  always_ff @(posedge aclk) begin
    if (!aresetn || !link_rx.sync_ok) begin
      rx_last_ff <= 16'h0;
      match_cnt_ff <= 2'h0;
      idle_cnt_ff <= 2'h0;
    end else begin
      if (link_rx.cfg_valid) begin
        rx_last_ff <= link_rx.word;
        idle_cnt_ff <= 2'h0;
        if ((link_rx.word & ACK_MASK) != (rx_last_ff & ACK_MASK)) begin
          match_cnt_ff <= 2'h1;
        end else if (match_cnt_ff != MATCH_CNT) begin
          match_cnt_ff <= match_cnt_ff + 2'h1;
        end
      end else if (link_rx.idle && idle_cnt_ff != MATCH_CNT) begin
        idle_cnt_ff <= idle_cnt_ff + 2'h1;
      end
    end
  end
  // three words in a row that agree apart from the ack bit count as reliable; a differing word restarts the count at one
  assign ability_match = match_cnt_ff == MATCH_CNT;
  assign ack_match = ability_match && rx_last_ff[ACK_BIT];
  assign idle_match = idle_cnt_ff == MATCH_CNT;

  // ==========================================================
  // link timer
  logic [TIMER_W-1:0] timer_ff, timer_lim;
  logic timer_done;
  always_comb begin
    if (short_tmr) begin
      timer_lim = TIMER_W'(LINK_TIMER_SHORT_CYC);
    end else if (mode_sgmii_ff) begin
      timer_lim = TIMER_W'(LINK_TIMER_SGMII_CYCLES);
    end else begin
      timer_lim = TIMER_W'(LINK_TIMER_X_CYCLES);
    end
  end
  assign timer_done = timer_ff == '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_ff <= '0;
    end else if (nxt_state != state_ff) begin
      timer_ff <= timer_lim - TIMER_W'(1);
    end else if (!timer_done) begin
      timer_ff <= timer_ff - TIMER_W'(1);
    end
  end

  // ==========================================================
  // negotiation state machine
  assign restart_evt = restart_req_ff || !link_rx.sync_ok || adv_chg_phy || mode_chg ||
                       (state_ff == S_LINK_OK && link_rx.cfg_valid);
  always_comb begin
    nxt_state = state_ff;
    if (!enable) begin
      nxt_state = S_DISABLED;
    end else if (restart_evt) begin
      nxt_state = S_START;
    end else begin
      case (state_ff)
        S_DISABLED: nxt_state = S_START;
        S_START: nxt_state = S_ABILITY;
        S_ABILITY: if (timer_done && ability_match) nxt_state = S_ACK;
        S_ACK: if (timer_done && ack_match) nxt_state = S_IDLE;
        S_IDLE: if (timer_done && idle_match) nxt_state = S_LINK_OK;
        S_LINK_OK: nxt_state = S_LINK_OK;
        default: nxt_state = S_START;
      endcase
    end
  end

  sgan_tx_t tx_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= S_START;
      tx_ff <= '0;
      done_ff <= 1'b0;
      page_rx_ff <= 1'b0;
      allowed_ff <= 1'b0;
      partner_ff <= 16'h0;
    end else begin
      state_ff <= nxt_state;
      done_ff <= nxt_state == S_LINK_OK;
      page_rx_ff <= nxt_state == S_ACK;
      allowed_ff <= nxt_state == S_LINK_OK || nxt_state == S_DISABLED;
      if (state_ff == S_ABILITY && nxt_state == S_ACK) begin
        partner_ff <= rx_last_ff;
      end
      tx_ff.cfg_en <= state_ff == S_START || state_ff == S_ABILITY || state_ff == S_ACK;
      tx_ff.idle_en <= !(state_ff == S_START || state_ff == S_ABILITY || state_ff == S_ACK);
      case (state_ff)
        S_ABILITY: tx_ff.word <= loc_word;
        S_ACK: tx_ff.word <= loc_word | (16'h1 << ACK_BIT);
        default: tx_ff.word <= 16'h0;
      endcase
    end
  end

  // ==========================================================
  // interrupts; a status read clears, a same-cycle event still sets
  assign irq_set = {nxt_state == S_ACK && state_ff != S_ACK,
                    state_ff == S_LINK_OK && nxt_state != S_LINK_OK,
                    nxt_state == S_LINK_OK && state_ff != S_LINK_OK};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_sts_ff <= ((rd_go && ra == OFS_IRQ_STS) ? '0 : irq_sts_ff) | irq_set;
      irq_ff <= |(irq_sts_ff & irq_mask_ff);
    end
  end

  assign link_tx = tx_ff;
  assign negotiation_done = done_ff;
  assign partner_page_received = page_rx_ff;
  assign partner_ability_word = partner_ff;
  assign data_allowed = allowed_ff;
  assign irq = irq_ff;
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // ==========================================================
  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  mac_word_a: assert property (state_ff == S_ABILITY && mode_sgmii_ff && !side_phy_ff
    |=> tx_ff.cfg_en && tx_ff.word == MAC_WORD) else $error("mac word wrong");
  ack_tx_a: assert property (state_ff == S_ACK |=> tx_ff.cfg_en && tx_ff.word[ACK_BIT])
    else $error("ack not sent");
  idle_tx_a: assert property (state_ff == S_IDLE |=> tx_ff.idle_en && !tx_ff.cfg_en)
    else $error("idle not sent");
  done_level_a: assert property (done_ff == (state_ff == S_LINK_OK))
    else $error("done not tied to link up");
  restart_in_a: assert property (restart_req_ff && enable |=> state_ff == S_START)
    else $error("restart ignored");
  bypass_a: assert property (!enable |=> state_ff == S_DISABLED && allowed_ff)
    else $error("bypass failed");
  sync_loss_a: assert property (enable && !link_rx.sync_ok |=> state_ff == S_START)
    else $error("sync loss ignored");
  phy_change_a: assert property (enable && adv_chg_phy |=> state_ff == S_START)
    else $error("phy change ignored");
  timer_load_a: assert property ($past(state_ff) == S_START && state_ff == S_ABILITY
    |-> timer_ff == timer_lim - TIMER_W'(1)) else $error("timer load wrong");
  early_exit_a: assert property (state_ff == S_ABILITY && !timer_done
    |=> state_ff != S_ACK) else $error("left before timer");
  link_hold_a: assert property (state_ff == S_LINK_OK && enable && !restart_evt
    |=> state_ff == S_LINK_OK [*1] ##0 done_ff) else $error("link up lost");
  link_entry_a: assert property ($rose(done_ff) |-> $past(idle_match))
    else $error("link up without idle");
  capture_a: assert property (page_rx_ff && !$past(page_rx_ff)
    |-> partner_ff == $past(rx_last_ff)) else $error("partner word not kept");
  link_up_c: cover property (state_ff == S_IDLE ##1 state_ff == S_LINK_OK);
  relink_c: cover property (state_ff == S_LINK_OK ##1 state_ff == S_START);
  phy_up_c: cover property (done_ff && mode_sgmii_ff && side_phy_ff);
  basex_up_c: cover property (done_ff && !mode_sgmii_ff);
endmodule

// ---- sim/sgan_link_partner.sv ----
`timescale 1ns/100ps
// ==========================================
// link partner pcs model, answers at once unless stalled
module sgan_link_partner import sgan_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire sgan_tx_t link_tx,
  input wire logic [15:0] own_word,
  input wire logic stall,
  input wire logic sync_lost,
  output sgan_rx_t link_rx
);
  logic [1:0] seen_ff;
  // acknowledge only after a few of our words arrived
  always_ff @(posedge aclk) begin
    if (!aresetn || !link_tx.cfg_en) begin
      seen_ff <= 2'h0;
    end else if (seen_ff != MATCH_CNT) begin
      seen_ff <= seen_ff + 2'h1;
    end
  end
  // an unused word line toggles so stale data never looks valid
  always_ff @(posedge aclk) begin
    link_rx.sync_ok <= aresetn & ~sync_lost;
    link_rx.cfg_valid <= 1'b0;
    link_rx.idle <= 1'b0;
    link_rx.word <= ~link_rx.word;
    if (!aresetn) begin
      link_rx.word <= 16'hA5A5;
    end else if (!stall && link_tx.idle_en) begin
      link_rx.idle <= 1'b1;
    end else if (!stall && link_tx.cfg_en) begin
      link_rx.cfg_valid <= 1'b1;
      link_rx.word <= {own_word[15], seen_ff == MATCH_CNT, own_word[13:0]};
    end
  end
endmodule

// ---- sim/tb_sgan_autoneg.sv ----
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module tb_sgan_autoneg import sgan_pkg::*;;
  // ==========================================
  // short timers keep the run small
  localparam int TX = 300;
  localparam int TS = 200;
  localparam int TSH = LINK_TIMER_SHORT_CYC;
  logic aclk, aresetn, mode_sgmii_pin, side_phy_pin;
  sgan_rx_t link_rx;
  sgan_tx_t link_tx;
  logic negotiation_done, partner_page_received, data_allowed, irq;
  logic [15:0] partner_ability_word, p_word;
  logic p_stall, p_sync_lost;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  int failures, cmp_count;

  always #4 aclk = ~aclk;

  sgan_autoneg #(.LINK_TIMER_X_CYCLES(TX), .LINK_TIMER_SGMII_CYCLES(TS)) DUT (
    .aclk(aclk), .aresetn(aresetn), .mode_sgmii_pin(mode_sgmii_pin),
    .side_phy_pin(side_phy_pin), .link_rx(link_rx), .link_tx(link_tx),
    .negotiation_done(negotiation_done), .partner_page_received(partner_page_received),
    .partner_ability_word(partner_ability_word), .data_allowed(data_allowed), .irq(irq),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  sgan_link_partner partner (.aclk(aclk), .aresetn(aresetn), .link_tx(link_tx),
    .own_word(p_word), .stall(p_stall), .sync_lost(p_sync_lost), .link_rx(link_rx));

  // ==========================================
  // bus tasks
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      aw_ok = aw_ok | awready;
      w_ok = w_ok | wready;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // a bounded wait, so a stuck machine shows as a mismatch, not a hang
  task wait_done(input string nm, input int lo, input int hi);
    int n;
    n = 0;
    while (negotiation_done !== 1'b1 && n < hi) begin
      @(posedge aclk);
      n++;
    end
    `CHK(nm, 1'b1, negotiation_done && n >= lo)
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================
  // scenarios
  task t_reset;
    `CHK("done_rst", 1'b0, negotiation_done)
    `CHK("irq_rst", 1'b0, irq)
    rd_reg(OFS_CTRL);
    `CHK("ctrl_rst", 32'h1, rd)
    rd_reg(OFS_IRQ_MASK);
    `CHK("mask_rst", 32'h0, rd)
    rd_reg(8'h40);
    `CHK("unmapped_resp", RESP_SLVERR, rs)
    `CHK("unmapped_data", 32'h0, rd)
    wr_reg(OFS_STATUS, 32'h0);
    `CHK("ro_resp", RESP_SLVERR, rs)
  endtask

  task t_basex;
    wr_reg(OFS_ADV, 32'hFFFF);
    wr_reg(OFS_CTRL, 32'h3);
    cyc(8);
    `CHK("cfg_en", 1'b1, link_tx.cfg_en)
    `CHK("basex_word", 16'hB1E0, link_tx.word)
    wait_done("basex_time", 3 * TX - 14, 3 * TX + 80);
    `CHK("allowed", 1'b1, data_allowed)
    `CHK("partner", p_word & ACK_MASK, partner_ability_word & ACK_MASK)
    `CHK("irq_masked", 1'b0, irq)
    wr_reg(OFS_IRQ_MASK, 32'h1);
    cyc(2);
    `CHK("irq_on", 1'b1, irq)
    rd_reg(OFS_IRQ_STS);
    `CHK("irq_sts", 1'b1, rd[IRQ_UP_BIT])
    cyc(2);
    `CHK("irq_clr", 1'b0, irq)
  endtask

  task t_mac;
    mode_sgmii_pin <= 1'b1;
    side_phy_pin <= 1'b0;
    cyc(10);
    `CHK("mac_word", MAC_WORD, link_tx.word)
    wait_done("mac_time", 3 * TS - 16, 3 * TS + 80);
  endtask

  task t_phy;
    int n;
    side_phy_pin <= 1'b1;
    cyc(10);
    `CHK("phy_word", 16'h9C01, link_tx.word)
    n = 0;
    while (partner_page_received !== 1'b1 && n < 2 * TS) begin
      @(posedge aclk);
      n++;
    end
    cyc(2);
    `CHK("ack_word", 16'hDC01, link_tx.word)
    `CHK("page_not_done", 1'b0, negotiation_done)
    wait_done("phy_time", 0, 3 * TS);
    wr_reg(OFS_ADV, 32'hEFFF);
    cyc(4);
    `CHK("adv_restart", 1'b0, negotiation_done)
    wait_done("phy_again", 3 * TS - 16, 3 * TS + 80);
  endtask

  task t_events;
    cyc(50);
    `CHK("held", 1'b1, negotiation_done)
    p_sync_lost <= 1'b1;
    cyc(4);
    `CHK("sync_loss", 1'b0, negotiation_done)
    p_sync_lost <= 1'b0;
    p_stall <= 1'b1;
    cyc(3 * TS + 100);
    `CHK("stalled", 1'b0, negotiation_done)
    p_stall <= 1'b0;
    wait_done("resume", 0, 3 * TS + 80);
    wr_reg(OFS_CTRL, 32'h7);
    cyc(4);
    `CHK("restart", 1'b0, negotiation_done)
    wait_done("short_time", 3 * TSH - 16, 3 * TSH + 80);
    wr_reg(OFS_CTRL, 32'h0);
    cyc(4);
    `CHK("dis_done", 1'b0, negotiation_done)
    `CHK("dis_allowed", 1'b1, data_allowed)
    wr_reg(OFS_CTRL, 32'h1);
    wait_done("reenable", 3 * TS - 8, 3 * TS + 80);
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    mode_sgmii_pin = 1'b0;
    side_phy_pin = 1'b0;
    p_word = 16'h01A0;
    p_stall = 1'b0;
    p_sync_lost = 1'b0;
    awvalid = 1'b0;
    awaddr = 8'h00;
    wvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    bready = 1'b0;
    arvalid = 1'b0;
    araddr = 8'h00;
    rready = 1'b0;
    failures = 0;
    cmp_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_basex;
    t_mac;
    t_phy;
    t_events;
    test_done;
  end

  // the scenarios need about 5500 cycles
  initial begin
    repeat (40000) @(posedge aclk);
    failures++;
    test_done;
  end
endmodule
